// [design/caac_defines.svh]
`ifndef CAAC_DEFINES_SVH
`define CAAC_DEFINES_SVH

// =====================================================================
// Attribute nibble layout: bit 3 write-through, 2 inhibit, 1 coherent, 0 guarded
`define CAAC_ATTR_W          3
`define CAAC_ATTR_I          2
`define CAAC_ATTR_M          1
`define CAAC_ATTR_G          0
`define CAAC_REAL_DATA_ATTR  4'h3
`define CAAC_REAL_INSTR_ATTR 4'h1
`define CAAC_ATTR_RESET      4'h0
`define CAAC_ADDR_RESET      32'h0000_0000
`define CAAC_MERGE_MAX       3'h4

`endif

// [design/caac_pkg.sv]
package caac_pkg;

    // =====================================================================
    // Request from the core for one translated access
    typedef struct packed {
        logic        valid;
        logic        is_fetch;
        logic        is_store;
        logic        is_prefetch;   // Out-of-order load or instruction prefetch
        logic        own_xlate;     // Effective address translated by this core
        logic        use_block;     // Block translation hit, else page entry
        logic [3:0]  block_attr;
        logic [3:0]  page_attr;
        logic [31:0] phys_addr;
    } caac_req_t;

    // Access plan handed to the cache control logic
    typedef struct packed {
        logic        valid;
        logic [3:0]  attr;
        logic [31:0] phys_addr;
        logic        cache_write;   // Update cached copy
        logic        mem_write;     // Send store to memory
        logic        allocate;      // May load/allocate into cache
        logic        bypass;        // Complete at main memory
        logic        global;        // Globally visible coherent access
        logic        blocked;       // Speculative access to guarded area
        logic        undefined;     // Unsupported or undefined attributes
        logic        mergeable;     // May combine with previous transfer
    } caac_plan_t;

    // Snoop answer from the coherence fabric
    typedef struct packed {
        logic valid;
        logic shared;
        logic modified;
    } caac_snoop_t;

    typedef enum logic [1:0] {
        CAAC_IDLE,
        CAAC_WAIT_SNOOP,
        CAAC_RETRY
    } caac_state_t;

    typedef struct packed {
        caac_state_t state;
        caac_plan_t  plan;
        logic        merge_open;
        logic [2:0]  merge_cnt;
        logic [3:0]  last_attr;
        logic [31:0] last_addr;
        logic        global_req;
        logic        retry;
        logic        shared;
        logic        busy;          // Registered copy of "not idle" for the output
    } caac_regs_t;

endpackage : caac_pkg

// [design/caac_ctrl.sv]
`timescale 1ns/1ns
`include "caac_defines.svh"

// Function
// [RULE1] Data real mode uses attribute 0011
// [RULE2] Fetch real mode uses attribute 0001
// [RULE3] Write-through store hit updates cache and memory
// [RULE4] Write-through store reaches globally visible level
// [RULE5] Merge write-through stores unless barrier intervenes
// [RULE6] Write-through store may write back block
// [RULE7] Write-back stores go to cache only
// [RULE8] Inhibited access bypasses cache, never allocates
// [RULE9] Inhibited merge blocked by barriers, guarded ordering (here the I/O barrier closes an inhibited merge only when guarded)
// [RULE10] Software keeps inhibited targets out of cache
// [RULE11] Coherent attribute forces coherence enforcement
// [RULE12] Coherent memory access signalled as global
// [RULE13] Snooped modified data forces retry
// [RULE14] Coherence attribute may be ignored on fetches
// [RULE15] Apply attributes only to own translations
// [RULE16] Instruction block write-through/guarded is undefined
// [RULE17] Aliased write-through mismatch coherent on one core
// [RULE18] Guarded forbids out-of-order loads and prefetches
// [RULE19] Same-address accesses kept in program order
// [RULE20] Attribute nibble from block or page entry
// [RULE21] Write-through with inhibit is unsupported
// [RULE22] Present attributes with address before hit decision
module caac_ctrl
    import caac_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire caac_req_t   req_in,
    input  wire logic        data_relocate_enable_in,
    input  wire logic        instr_relocate_enable_in,
    input  wire logic        full_barrier_in,
    input  wire logic        io_barrier_in,
    input  wire caac_snoop_t snoop_in,
    output logic             busy_out,
    output caac_plan_t       plan_out,
    output logic             global_req_out,
    output logic             retry_out,
    output logic             shared_out
);

    // =====================================================================
    // State
    caac_regs_t state_reg;
    caac_regs_t state_next;

    logic [3:0] attr_sel;
    logic       relocate;
    logic       accept;

    // =====================================================================
    // Attribute resolution
    always_comb
    begin
        relocate = req_in.is_fetch ? instr_relocate_enable_in : data_relocate_enable_in;
        if (!relocate)
        begin
            // Real mode: fixed attributes, everything guarded
            attr_sel = req_in.is_fetch ? `CAAC_REAL_INSTR_ATTR   // see [RULE2]
                                       : `CAAC_REAL_DATA_ATTR;   // see [RULE1]
        end
        else
        begin
            attr_sel = req_in.use_block ? req_in.block_attr : req_in.page_attr; // see [RULE20]
        end
        // Fetches ignore coherence; instruction memory need not track data
        if (req_in.is_fetch)
        begin
            attr_sel[`CAAC_ATTR_M] = 1'b0; // see [RULE14]
        end
    end

    // Requests only taken while no coherent access awaits its snoop, which keeps
    // same-address accesses in program order at the cost of a stall
    assign accept = req_in.valid && (state_reg.state == CAAC_IDLE); // see [RULE19] [RULE17]

    // =====================================================================
    // Next-state logic
    always_comb
    begin
        state_next = state_reg;
        state_next.plan.valid = 1'b0;
        state_next.retry = 1'b0;

        // A full barrier closes any open merge window; an I/O barrier only after a write-through or guarded access
        if (full_barrier_in)
        begin
            state_next.merge_open = 1'b0; // see [RULE5]
        end
        if (io_barrier_in && (state_reg.last_attr[`CAAC_ATTR_W] ||
                              state_reg.last_attr[`CAAC_ATTR_G]))
        begin
            state_next.merge_open = 1'b0; // see [RULE9]
        end

        unique case (state_reg.state)
            CAAC_IDLE:
            begin
                // Foreign accesses pass untouched: attributes never attach to them
                if (accept && req_in.own_xlate) // see [RULE15]
                begin
                    state_next.plan.valid       = 1'b1;
                    state_next.plan.attr        = attr_sel;             // see [RULE22]
                    state_next.plan.phys_addr   = req_in.phys_addr;
                    state_next.plan.bypass      = attr_sel[`CAAC_ATTR_I]; // see [RULE8]
                    state_next.plan.allocate    = !attr_sel[`CAAC_ATTR_I];
                    // Store hits update the cache unless inhibited
                    state_next.plan.cache_write = req_in.is_store &&
                                                  !attr_sel[`CAAC_ATTR_I]; // see [RULE3]
                    // Write-back stores stay in cache; write-through goes to the shared level
                    // The cache may carry the rest of the block along with it // see [RULE6]
                    state_next.plan.mem_write   = req_in.is_store &&
                                                  (attr_sel[`CAAC_ATTR_W] || // see [RULE4]
                                                   attr_sel[`CAAC_ATTR_I]); // see [RULE7]
                    state_next.plan.global      = attr_sel[`CAAC_ATTR_M] &&
                                                  (attr_sel[`CAAC_ATTR_I] ||
                                                   attr_sel[`CAAC_ATTR_W] ||
                                                   !req_in.is_store); // see [RULE11]
                    state_next.plan.blocked     = req_in.is_prefetch &&
                                                  attr_sel[`CAAC_ATTR_G]; // see [RULE18]
                    state_next.plan.undefined   = (attr_sel[`CAAC_ATTR_W] &&
                                                   attr_sel[`CAAC_ATTR_I]) ||   // see [RULE21]
                                                  (req_in.is_fetch && relocate &&
                                                   req_in.use_block &&
                                                   (req_in.block_attr[`CAAC_ATTR_W] ||
                                                    req_in.block_attr[`CAAC_ATTR_G])); // see [RULE16]
                    // Stores merge only with same attribute class and open window
                    state_next.plan.mergeable   = req_in.is_store && state_next.merge_open &&
                                                  (attr_sel == state_reg.last_attr) &&
                                                  (attr_sel[`CAAC_ATTR_W] ||
                                                   attr_sel[`CAAC_ATTR_I]) &&
                                                  (state_reg.merge_cnt < `CAAC_MERGE_MAX); // see [RULE5]
                    state_next.merge_cnt  = state_next.plan.mergeable ?
                                            3'(state_reg.merge_cnt + 3'h1) : 3'h1;
                    state_next.merge_open = req_in.is_store;
                    state_next.last_attr  = attr_sel;
                    state_next.last_addr  = req_in.phys_addr;
                    // Coherent memory access raises the global indication, except write-back stores and blocked accesses
                    if (state_next.plan.global && !state_next.plan.blocked)
                    begin
                        state_next.global_req = 1'b1; // see [RULE12]
                        state_next.state      = CAAC_WAIT_SNOOP;
                    end
                end
            end
            CAAC_WAIT_SNOOP:
            begin
                if (snoop_in.valid)
                begin
                    state_next.global_req = 1'b0;
                    state_next.shared     = snoop_in.shared;
                    // Another holder had it modified: memory updated, we retry
                    if (snoop_in.modified) // see [RULE13]
                    begin
                        state_next.retry = 1'b1;
                        state_next.state = CAAC_RETRY;
                    end
                    else
                    begin
                        state_next.state = CAAC_IDLE;
                    end
                end
            end
            CAAC_RETRY:
            begin
                // Reissue the same global access
                state_next.global_req = 1'b1; // see [RULE13]
                state_next.state      = CAAC_WAIT_SNOOP;
            end
        endcase
        // Busy is registered so the output needs no logic after the flop
        state_next.busy = (state_next.state != CAAC_IDLE);
    end

    // =====================================================================
    // Registers
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state_reg            <= '0;
            state_reg.state      <= CAAC_IDLE;
            state_reg.last_attr  <= `CAAC_ATTR_RESET;
            state_reg.last_addr  <= `CAAC_ADDR_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flops
    assign plan_out       = state_reg.plan;
    assign global_req_out = state_reg.global_req;
    assign retry_out      = state_reg.retry;
    assign shared_out     = state_reg.shared;
    assign busy_out       = state_reg.busy;

endmodule : caac_ctrl

// [test/caac_ctrl_checker.sv]
`timescale 1ns/1ns
// =====================================================================
// Port checker for the access attribute controller
module caac_ctrl_checker
    import caac_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire caac_req_t   req_in,
    input wire logic        data_relocate_enable_in,
    input wire logic        instr_relocate_enable_in,
    input wire logic        full_barrier_in,
    input wire logic        io_barrier_in,
    input wire caac_snoop_t snoop_in,
    input wire logic        busy_out,
    input wire caac_plan_t  plan_out,
    input wire logic        global_req_out,
    input wire logic        retry_out,
    input wire logic        shared_out
);
    logic       tk;
    logic       rl;
    logic [3:0] ea;
    // Taken request and the nibble it should resolve to, so each check names its cause
    assign tk = req_in.valid && req_in.own_xlate && !busy_out;
    assign rl = req_in.is_fetch ? instr_relocate_enable_in : data_relocate_enable_in;
    assign ea = rl ? (req_in.use_block ? req_in.block_attr : req_in.page_attr)
                   : (req_in.is_fetch ? 4'h1 : 4'h3);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_retry;
        retry_out ##1 global_req_out;
    endsequence
    a_real_data: assert property (tk && !rl && !req_in.is_fetch |=> plan_out.attr == 4'h3)
        else $error("real mode data nibble wrong");
    a_real_fetch: assert property (tk && !rl && req_in.is_fetch |=> plan_out.attr == 4'h1)
        else $error("real mode fetch nibble wrong");
    a_attr_source: assert property (tk && !req_in.is_fetch |=> plan_out.attr == $past(ea))
        else $error("nibble not taken from selected entry");
    a_wt_store: assert property (tk && req_in.is_store && ea[3:2] == 2'b10
        |=> plan_out.mem_write && plan_out.cache_write)
        else $error("write-through store not sent to both");
    a_wb_store: assert property (tk && req_in.is_store && ea[3:2] == 2'b00
        |=> !plan_out.mem_write && plan_out.cache_write)
        else $error("write-back store left cache");
    a_inhibit_bypass: assert property (tk && ea[2]
        |=> plan_out.bypass && !plan_out.allocate && !plan_out.cache_write)
        else $error("inhibited access touched cache");
    a_guard_block: assert property (tk && req_in.is_prefetch && ea[0]
        |=> plan_out.blocked && !global_req_out)
        else $error("guarded prefetch not blocked");
    a_unsupported_combo: assert property (tk && rl && ea[3:2] == 2'b11
        |=> plan_out.undefined)
        else $error("unsupported nibble not flagged");
    a_global_hold: assert property (global_req_out && !snoop_in.valid |=> global_req_out)
        else $error("global request dropped before answer");
    a_modified_retry: assert property (global_req_out && snoop_in.valid && snoop_in.modified
        |=> s_retry)
        else $error("modified answer without retry");
endmodule : caac_ctrl_checker

bind caac_ctrl caac_ctrl_checker caac_ctrl_checker_inst (.clk_in, .srst_in, .req_in,
    .data_relocate_enable_in, .instr_relocate_enable_in, .full_barrier_in, .io_barrier_in,
    .snoop_in, .busy_out, .plan_out, .global_req_out, .retry_out, .shared_out);

// [test/caac_fabric_model.sv]
`timescale 1ns/1ns
// =====================================================================
// Coherence fabric: answers each global access after a set delay
module caac_fabric_model
    import caac_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       global_req_in,
    input  wire logic [3:0] lat_in,
    input  wire logic       shared_in,
    input  wire logic       mod_once_in,
    output caac_snoop_t     snoop_out
);
    logic [3:0] cnt_reg;
    logic       used_reg;
    // Idle answer fields flip so a stale flag is never mistaken for fresh
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            cnt_reg   <= 4'h0;
            used_reg  <= 1'b0;
            snoop_out <= '0;
        end
        else if (snoop_out.valid || !global_req_in)
        begin
            cnt_reg   <= 4'h0;
            snoop_out <= '{1'b0, ~snoop_out.shared, ~snoop_out.modified};
        end
        else if (cnt_reg == lat_in)
        begin
            snoop_out <= '{1'b1, shared_in, mod_once_in && !used_reg};
            used_reg  <= used_reg | mod_once_in;
        end
        else
            cnt_reg <= cnt_reg + 4'h1;
    end
endmodule : caac_fabric_model

// [test/caac_ctrl_tb.sv]
`timescale 1ns/1ns
// =====================================================================
// Testbench for the access attribute controller
module caac_ctrl_tb
    import caac_pkg::*;
;
    logic clk_in, srst_in, data_relocate_enable_in, instr_relocate_enable_in;
    logic full_barrier_in, io_barrier_in, busy_out, global_req_out, retry_out, shared_out;
    logic shr, modo;
    logic [3:0] lat;
    caac_req_t   req_in;
    caac_snoop_t snoop_in;
    caac_plan_t  plan_out, pl;
    int failures, n_tests, n_retry;

    caac_ctrl caac_ctrl_inst (.clk_in, .srst_in, .req_in, .data_relocate_enable_in,
        .instr_relocate_enable_in, .full_barrier_in, .io_barrier_in, .snoop_in, .busy_out,
        .plan_out, .global_req_out, .retry_out, .shared_out);
    caac_fabric_model caac_fabric_model_inst (.clk_in, .srst_in, .global_req_in(global_req_out),
        .lat_in(lat), .shared_in(shr), .mod_once_in(modo), .snoop_out(snoop_in));

    // Clock at 125 MHz; retry pulses counted mid-cycle, clear of the launching edge
    always #4 clk_in = ~clk_in;
    always @(negedge clk_in)
    begin
        if (retry_out === 1'b1)
            n_retry++;
    end

    // =====================================================================
    // Access and compare tasks
    task send(input logic [4:0] k, input logic [3:0] ba, input logic [3:0] pa);
        req_in = '{1'b1, k[4], k[3], k[2], k[1], k[0], ba, pa, 32'h0000_1000};
        @(negedge clk_in);
        pl = plan_out;
        req_in.valid = 1'b0;
        // One idle cycle keeps back-to-back calls from re-raising valid in one step
        @(negedge clk_in);
        for (int i = 0; i < 40 && busy_out !== 1'b0; i++)
            @(negedge clk_in);
        // A snoop that never finishes counts against the run
        if (busy_out !== 1'b0)
        begin
            failures++;
            $display("unexpected at %0t: %h vs %h", $time, busy_out, 1'b0);
        end
    endtask : send
    task chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
        $display("test done at %0t", $time);
    endtask : chk_bit
    task chk_plan(input logic [3:0] ea, input logic [6:0] ef);
        logic [43:0] g;
        g = {pl.valid, pl.attr, pl.cache_write, pl.mem_write, pl.allocate, pl.bypass,
             pl.global, pl.blocked, pl.undefined, pl.phys_addr};
        n_tests++;
        if (g !== {1'b1, ea, ef, 32'h0000_1000})
        begin
            failures++;
            $display("unexpected at %0t: %h vs %h", $time, g, {1'b1, ea, ef, 32'h0000_1000});
        end
        $display("test done at %0t", $time);
    endtask : chk_plan
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // Watchdog at 5000 cycles: the sequence needs under a hundred cycles
    initial begin #40000; failures++; wrap_up; end

    // =====================================================================
    // Main sequence
    initial
    begin
        clk_in = 1'b0; srst_in = 1'b1; req_in = '0; full_barrier_in = 1'b0; io_barrier_in = 1'b0;
        data_relocate_enable_in = 1'b0; instr_relocate_enable_in = 1'b0;
        lat = 4'h2; shr = 1'b1; modo = 1'b0;
        repeat (12) @(negedge clk_in);
        srst_in = 1'b0;
        chk_bit(busy_out | global_req_out | retry_out | shared_out | plan_out.valid, 1'b0);
        send(5'b00010, 4'h0, 4'h0); chk_plan(4'h3, 7'b0010100);
        chk_bit(shared_out, 1'b1);
        send(5'b10010, 4'h0, 4'h0); chk_plan(4'h1, 7'b0010000);
        data_relocate_enable_in = 1'b1; instr_relocate_enable_in = 1'b1; lat = 4'h0;
        send(5'b01010, 4'h0, 4'h8); chk_plan(4'h8, 7'b1110000);
        send(5'b01010, 4'h0, 4'h0); chk_plan(4'h0, 7'b1010000);
        // Inhibited target sent with no cached copy anywhere
        send(5'b00011, 4'h4, 4'h0); chk_plan(4'h4, 7'b0001000);
        send(5'b00000, 4'h0, 4'h0); chk_bit(pl.valid, 1'b0);
        send(5'b00111, 4'h1, 4'h0); chk_plan(4'h1, 7'b0010010);
        send(5'b00011, 4'hC, 4'h0); chk_plan(4'hC, 7'b0001001);
        send(5'b10010, 4'h0, 4'h2); chk_plan(4'h0, 7'b0010000);
        send(5'b10011, 4'h8, 4'h0); chk_plan(4'h8, 7'b0010001);
        modo = 1'b1; shr = 1'b0;
        send(5'b00010, 4'h0, 4'h2); chk_plan(4'h2, 7'b0010100);
        chk_bit(n_retry == 1, 1'b1);
        chk_bit(shared_out, 1'b0);
        // Merge window: four stores at most, closed by each barrier kind
        send(5'b01010, 4'h0, 4'h8); chk_bit(pl.mergeable, 1'b0);
        repeat (3)
        begin
            send(5'b01010, 4'h0, 4'h8); chk_bit(pl.mergeable, 1'b1);
        end
        send(5'b01010, 4'h0, 4'h8); chk_bit(pl.mergeable, 1'b0);
        send(5'b01010, 4'h0, 4'h8); chk_bit(pl.mergeable, 1'b1);
        full_barrier_in = 1'b1; @(negedge clk_in); full_barrier_in = 1'b0;
        send(5'b01010, 4'h0, 4'h8); chk_bit(pl.mergeable, 1'b0);
        send(5'b01010, 4'h0, 4'h8); chk_bit(pl.mergeable, 1'b1);
        io_barrier_in = 1'b1; @(negedge clk_in); io_barrier_in = 1'b0;
        send(5'b01010, 4'h0, 4'h8); chk_bit(pl.mergeable, 1'b0);
        // Inhibited stores: an I/O barrier closes the window only when guarded
        send(5'b01010, 4'h0, 4'h4); chk_bit(pl.mergeable, 1'b0);
        send(5'b01010, 4'h0, 4'h4); chk_bit(pl.mergeable, 1'b1);
        io_barrier_in = 1'b1; @(negedge clk_in); io_barrier_in = 1'b0;
        send(5'b01010, 4'h0, 4'h4); chk_bit(pl.mergeable, 1'b1);
        send(5'b01010, 4'h0, 4'h5); chk_bit(pl.mergeable, 1'b0);
        send(5'b01010, 4'h0, 4'h5); chk_bit(pl.mergeable, 1'b1);
        io_barrier_in = 1'b1; @(negedge clk_in); io_barrier_in = 1'b0;
        send(5'b01010, 4'h0, 4'h5); chk_bit(pl.mergeable, 1'b0);
        wrap_up;
    end
endmodule : caac_ctrl_tb
